/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
	logic        clk_sys, sys_rst, audio_en, mode_i2s, rate_48k, tx_valid, cfg_valid, other_n;
	logic [15:0] tx_data;
	logic [6:0]  dev_addr;
	logic [7:0]  reg_addr, wr_data, i2c_byte;
	wire         tx_ready, tx_underrun, rx_valid, rx_slot, bclk, fsync, dout, din, ref_clk;
	wire         cfg_ready, cfg_done, cfg_nack, cfg_arb, scl_oe_n, sda_oe_n, scl_w, sda_w;
	wire  [15:0] rx_data;
	int          err_count, samples_checked, i2c_bits;

	assign scl_w = scl_oe_n;
	assign sda_w = sda_oe_n & other_n;

	vsap_port dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(1'b1), .AUDIO_EN(audio_en),
		.MODE_I2S(mode_i2s), .RATE_48K(rate_48k), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_DATA(tx_data), .TX_UNDERRUN(tx_underrun), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_SLOT(rx_slot), .BCLK_OUT(bclk), .FSYNC_OUT(fsync), .DOUT(dout), .DIN(din),
		.CODEC_REFERENCE_CLOCK_OUT(ref_clk), .CFG_VALID(cfg_valid), .CFG_READY(cfg_ready),
		.CFG_DEV_ADDR(dev_addr), .CFG_REG_ADDR(reg_addr), .CFG_WR_DATA(wr_data),
		.CFG_DONE(cfg_done), .CFG_NACK(cfg_nack), .CFG_ARB_LOST(cfg_arb),
		.I2C_SCL_IN(scl_w), .I2C_SCL_OUT(), .I2C_SCL_OE_N(scl_oe_n), .I2C_SDA_IN(sda_w),
		.I2C_SDA_OUT(), .I2C_SDA_OE_N(sda_oe_n));
	vsap_codec_model m (.rst(sys_rst | ~audio_en), .mode_i2s(mode_i2s), .bclk(bclk),
		.fsync(fsync), .dout(dout), .din(din));

	always #50 clk_sys = ~clk_sys;
	always @(negedge sda_w) if (scl_w === 1'b1) i2c_bits = 0;
	always @(posedge scl_w) begin
		if (i2c_bits < 8) begin
			i2c_byte = {i2c_byte[6:0], sda_w};
			i2c_bits++;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Another master owns the bus first; no target answers, so the address is refused
	task automatic cfg_shared;
		int k, early;
		dev_addr = 7'h1c;
		reg_addr = 8'h0a;
		wr_data = 8'hc3;
		other_n = 1'b0;
		cfg_valid = 1'b1;
		cyc(1);
		cfg_valid = 1'b0;
		early = 0;
		for (k = 0; k < 200; k++) begin
			cyc(1);
			early += int'(sda_oe_n !== 1'b1);
		end
		check(16'(early), 16'h0000, "start while bus busy");
		other_n = 1'b1;
		for (k = 0; k < 5000 && cfg_done !== 1'b1; k++) cyc(1);
		check(16'(k < 5000), 16'h0001, "config done");
		check({15'h0, cfg_nack}, 16'h0001, "config nack");
		check({15'h0, cfg_arb}, 16'h0000, "config arbitration");
		check({8'h00, i2c_byte}, {8'h00, dev_addr, 1'b0}, "address byte");
		// Second request: the other master sends a zero where our address has a one
		cfg_valid = 1'b1;
		cyc(1);
		cfg_valid = 1'b0;
		for (k = 0; k < 2000 && !(i2c_bits == 2 && scl_w === 1'b0); k++) cyc(1);
		check(16'(k < 2000), 16'h0001, "lost sync");
		other_n = 1'b0;
		for (k = 0; k < 2000 && cfg_done !== 1'b1; k++) cyc(1);
		other_n = 1'b1;
		check(16'(k < 2000), 16'h0001, "lost done");
		check({15'h0, cfg_arb}, 16'h0001, "arbitration lost");
		check({15'h0, cfg_nack}, 16'h0000, "lost nack");
		check({14'h0, scl_oe_n, sda_oe_n}, 16'h0003, "lost release");
	endtask

	task automatic run_link(input logic i2s, input logic r48, input int nw, input int ns);
		logic [15:0] pushed[$];
		int base, n, und, k;
		mode_i2s = i2s;
		rate_48k = r48;
		base = m.sent;
		m.got.delete();
		audio_en = 1'b1;
		cyc(2);
		tx_valid = 1'b1;
		for (k = 0; k < nw; k++) begin
			tx_data = 16'h7ff0 ^ 16'(k * 16'h9111);
			pushed.push_back(tx_data);
			cyc(1);
		end
		if (nw == 8) begin
			check({15'h0, tx_ready}, 16'h0000, "buffer full");
			tx_data = 16'h5a5a;
			cyc(1);
		end
		tx_valid = 1'b0;
		n = 0;
		und = 0;
		for (k = 0; k < 8000 && n < ns; k++) begin
			cyc(1);
			und += tx_underrun;
			if (rx_valid === 1'b1) begin
				check(rx_data, 16'h8001 + 16'(base + n) * 16'h0a53, "rx word");
				check({15'h0, rx_slot}, {15'h0, i2s & n[0]}, "rx slot");
				n++;
			end
		end
		check(16'(n), 16'(ns), "rx count");
		audio_en = 1'b0;
		cyc(4);
		check(16'(m.got.size() >= nw), 16'h0001, "codec count");
		foreach (m.got[i]) check(m.got[i], i < nw ? pushed[i] : 16'h0000, "codec word");
		check(16'(und >= ns - nw && und <= ns - nw + 1), 16'h0001, "underrun count");
	endtask

	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		{audio_en, mode_i2s, rate_48k, tx_valid, cfg_valid} = 5'h00;
		other_n = 1'b1;
		tx_data = 16'h0000;
		dev_addr = 7'h00;
		reg_addr = 8'h00;
		wr_data = 8'h00;
		i2c_bits = 8;
		err_count = 0;
		samples_checked = 0;
		cyc(3);
		sys_rst = 1'b0;
		cfg_shared();
		run_link(1'b0, 1'b0, 8, 10);
		run_link(1'b0, 1'b1, 3, 5);
		run_link(1'b1, 1'b0, 4, 6);
		run_link(1'b1, 1'b1, 6, 9);
		stop_test();
	end
endmodule // tb

/* File: verification/vsap_codec_model.sv */
`timescale 1ns/100ps
module vsap_codec_model (
	input  wire logic rst,
	input  wire logic mode_i2s,
	input  wire logic bclk,
	input  wire logic fsync,
	input  wire logic dout,
	output logic      din
);
	logic [15:0] tx_q;
	logic [15:0] rx_q;
	logic [3:0]  idx_q;
	logic        fs_q;
	logic        start_q;
	int          sent;
	int          starts;
	logic [15:0] got[$];

	// Known start so the first frame does not race the time-zero reset
	initial begin
		sent = 0;
		starts = 0;
		idx_q = 4'hf;
		start_q = 1'b0;
		fs_q = 1'b0;
		din = 1'b0;
	end
	// Local role: only follows the host's clock and sync, never leads
	always @(posedge rst or posedge bclk) begin
		if (rst) begin
			idx_q = 4'hf;
			start_q = 1'b0;
			fs_q = 1'b0;
			starts = 0;
			din = ~din;
		end else begin
			rx_q = {rx_q[14:0], dout};
			start_q = mode_i2s ? (fsync != fs_q) : fsync;
			fs_q = fsync;
		end
	end
	// A stopping host drops its clock once more; that edge opens no word
	always @(negedge bclk) begin
		if (!rst) begin
			if (start_q || idx_q == 4'hf) begin
				if (starts > 0)
					got.push_back(rx_q);
				starts++;
				tx_q = 16'h8001 + 16'(sent) * 16'h0a53;
				sent++;
				idx_q = 4'h0;
			end else begin
				idx_q = idx_q + 4'h1;
			end
			din = tx_q[4'hf - idx_q];
		end
	end
endmodule // vsap_codec_model

/* File: verification/vsap_port_props.sv */
`timescale 1ns/100ps
module vsap_port_props #(
	parameter int REF_HALF = 2
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic AUDIO_EN,
	input wire logic MODE_I2S,
	input wire logic RATE_48K,
	input wire logic BCLK_OUT,
	input wire logic FSYNC_OUT,
	input wire logic DOUT,
	input wire logic RX_VALID,
	input wire logic RX_SLOT,
	input wire logic CODEC_REFERENCE_CLOCK_OUT,
	input wire logic CFG_VALID,
	input wire logic CFG_READY,
	input wire logic I2C_SCL_OE_N,
	input wire logic I2C_SDA_OE_N
);
	logic [7:0] half_q;
	logic [5:0] nfall_q;
	logic       bc_arm_q;
	logic       fs_arm_q;
	logic       seen_q;
	logic [7:0] ref_q;
	logic       ref_arm_q;
	logic [7:0] half_lo;
	// Fractional accumulator: each half period is one of two whole counts
	assign half_lo = MODE_I2S ? (RATE_48K ? 8'h03 : 8'h09) : (RATE_48K ? 8'h06 : 8'h13);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST || !AUDIO_EN) begin
			half_q   <= 8'h00;
			nfall_q  <= 6'h00;
			bc_arm_q <= 1'b0;
			fs_arm_q <= 1'b0;
			seen_q   <= 1'b0;
		end else begin
			half_q   <= $changed(BCLK_OUT) ? 8'h01 : half_q + 8'h01;
			nfall_q  <= ($rose(FSYNC_OUT) ? 6'h00 : nfall_q) + 6'($fell(BCLK_OUT));
			bc_arm_q <= bc_arm_q || $changed(BCLK_OUT);
			fs_arm_q <= fs_arm_q || ($rose(FSYNC_OUT) && $fell(BCLK_OUT));
			seen_q   <= seen_q || $fell(BCLK_OUT);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ref_q     <= 8'h00;
			ref_arm_q <= 1'b0;
		end else begin
			ref_q     <= $changed(CODEC_REFERENCE_CLOCK_OUT) ? 8'h01 : ref_q + 8'h01;
			ref_arm_q <= ref_arm_q || $changed(CODEC_REFERENCE_CLOCK_OUT);
		end
	end

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	idle_link_a: assert property (
		!AUDIO_EN [*3] |-> !BCLK_OUT && !FSYNC_OUT) else $error("link active while off");
	bclk_half_a: assert property (
		$changed(BCLK_OUT) && bc_arm_q |-> half_q inside {[half_lo:half_lo + 8'h01]})
		else $error("bit clock half period off");
	frame_len_a: assert property (
		$rose(FSYNC_OUT) && fs_arm_q |-> nfall_q == (MODE_I2S ? 6'h20 : 6'h10))
		else $error("frame length off");
	sync_width_a: assert property (
		$fell(FSYNC_OUT) && fs_arm_q |-> nfall_q == (MODE_I2S ? 6'h10 : 6'h01))
		else $error("sync width off");
	dout_edge_a: assert property (
		seen_q && $changed(DOUT) |-> $fell(BCLK_OUT)) else $error("data moved off falling edge");
	rx_slot_a: assert property (
		RX_VALID && AUDIO_EN |-> FSYNC_OUT == !RX_SLOT) else $error("receive slot off");
	rx_pulse_a: assert property (
		RX_VALID |=> !RX_VALID) else $error("receive strobe too long");
	bus_free_a: assert property (
		CFG_VALID && CFG_READY |=> I2C_SDA_OE_N [*8]) else $error("start without free wait");
	bus_release_a: assert property (
		CFG_READY |-> I2C_SCL_OE_N && I2C_SDA_OE_N) else $error("bus held while idle");
	ref_clock_a: assert property (
		$changed(CODEC_REFERENCE_CLOCK_OUT) && ref_arm_q |-> ref_q == 8'(REF_HALF))
		else $error("reference clock period off");
endmodule // vsap_port_props

bind vsap_port vsap_port_props #(.REF_HALF(REF_HALF)) u_props (
	.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AUDIO_EN(AUDIO_EN), .MODE_I2S(MODE_I2S),
	.RATE_48K(RATE_48K), .BCLK_OUT(BCLK_OUT), .FSYNC_OUT(FSYNC_OUT), .DOUT(DOUT),
	.RX_VALID(RX_VALID), .RX_SLOT(RX_SLOT),
	.CODEC_REFERENCE_CLOCK_OUT(CODEC_REFERENCE_CLOCK_OUT), .CFG_VALID(CFG_VALID),
	.CFG_READY(CFG_READY), .I2C_SCL_OE_N(I2C_SCL_OE_N), .I2C_SDA_OE_N(I2C_SDA_OE_N));

/* File: verilog/vsap_fifo.sv */
`timescale 1ns/100ps
module vsap_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire              empty = (wr_q == rd_q);
	wire              push  = ce && in_valid && !full;
	wire              pop   = ce && out_ready && !empty;

	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule // vsap_fifo

/* File: verilog/vsap_pkg.sv */
package vsap_pkg;
	// System clock
	localparam int unsigned CLK_HZ_INT = 10_000_000;
	localparam logic [24:0] CLK_HZ     = 25'(CLK_HZ_INT);

	// Audio framing
	localparam int unsigned WORD_BITS      = 16;
	localparam int unsigned PCM_FRAME_BITS = 16;
	localparam int unsigned I2S_FRAME_BITS = 32;
	localparam logic [3:0]  WORD_LAST      = 4'(WORD_BITS - 1);
	localparam logic [3:0]  WORD_FIRST     = 4'h0;
	localparam logic [4:0]  PCM_LAST       = 5'(PCM_FRAME_BITS - 1);
	localparam logic [4:0]  I2S_LAST       = 5'(I2S_FRAME_BITS - 1);
	localparam logic [4:0]  I2S_WS_RISE    = 5'(WORD_BITS - 1);
	localparam logic [4:0]  BIT_FIRST      = 5'h00;
	localparam int unsigned RATE_LO_HZ     = 16_000;
	localparam int unsigned RATE_HI_HZ     = 48_000;

	// Bit-clock phase increments: two toggles per bit, accumulated modulo CLK_HZ
	localparam logic [24:0] INC_PCM_LO = 25'(2 * PCM_FRAME_BITS * RATE_LO_HZ);
	localparam logic [24:0] INC_PCM_HI = 25'(2 * PCM_FRAME_BITS * RATE_HI_HZ);
	localparam logic [24:0] INC_I2S_LO = 25'(2 * I2S_FRAME_BITS * RATE_LO_HZ);
	localparam logic [24:0] INC_I2S_HI = 25'(2 * I2S_FRAME_BITS * RATE_HI_HZ);

	// Control bus timing, least quarter period of the serial clock
	localparam int unsigned I2C_QUARTER_NS  = 2500;
	localparam int unsigned I2C_QUARTER_CYC =
		(I2C_QUARTER_NS * (CLK_HZ_INT / 1_000_000) + 999) / 1000;
	localparam logic [11:0] I2C_Q_LAST      = 12'(I2C_QUARTER_CYC - 1);
	localparam logic [1:0]  I2C_BYTE_LAST   = 2'h2;
	localparam logic [3:0]  I2C_ACK_BIT     = 4'h8;

	// Codec reference clock default half period in system cycles
	localparam int unsigned REF_HALF_DEFAULT = 2;

	typedef enum logic [8:0] {
		I2C_IDLE  = 9'h001,
		I2C_FREE  = 9'h002,
		I2C_START = 9'h004,
		I2C_LOW   = 9'h008,
		I2C_HIGH  = 9'h010,
		I2C_STOPA = 9'h020,
		I2C_STOPB = 9'h040,
		I2C_STOPC = 9'h080,
		I2C_DONE  = 9'h100
	} vsap_i2c_t;
endpackage

/* File: verilog/vsap_port.sv */
// How it works
// - This block is always the serial audio host and drives the bit clock and frame sync.
// - Framing is either short-sync PCM or long-sync normal I2S, chosen by MODE_I2S.
// - Samples pass as linear two's complement values, untouched in both directions.
// - Each word is 16 bits over sixteen bit clocks, most significant bit first.
// - In PCM mode the frame is 16 bit clocks and each MSB follows the previous LSB directly.
// - In I2S mode the frame is 32 bit clocks holding two 16-bit slots.
// - The frame rate is 16 kHz or 48 kHz, chosen by RATE_48K.
// - The bit clock runs at 16 times the rate in PCM mode and 32 times it in I2S mode.
// - A separate reference clock for the codec is driven independently of the bit clock.
// - The codec is configured by a byte-write control bus master that shares the bus.
`timescale 1ns/100ps
module vsap_port #(
	parameter int FIFO_DEPTH = 8,
	parameter int REF_HALF   = vsap_pkg::REF_HALF_DEFAULT
) (
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	input  wire logic        CLK_EN,
	input  wire logic        AUDIO_EN,
	input  wire logic        MODE_I2S,
	input  wire logic        RATE_48K,
	input  wire logic        TX_VALID,
	output logic             TX_READY,
	input  wire logic [15:0] TX_DATA,
	output logic             TX_UNDERRUN,
	output logic             RX_VALID,
	output logic      [15:0] RX_DATA,
	output logic             RX_SLOT,
	output logic             BCLK_OUT,
	output logic             FSYNC_OUT,
	output logic             DOUT,
	input  wire logic        DIN,
	output logic             CODEC_REFERENCE_CLOCK_OUT,
	input  wire logic        CFG_VALID,
	output logic             CFG_READY,
	input  wire logic [6:0]  CFG_DEV_ADDR,
	input  wire logic [7:0]  CFG_REG_ADDR,
	input  wire logic [7:0]  CFG_WR_DATA,
	output logic             CFG_DONE,
	output logic             CFG_NACK,
	output logic             CFG_ARB_LOST,
	input  wire logic        I2C_SCL_IN,
	output logic             I2C_SCL_OUT,
	output logic             I2C_SCL_OE_N,
	input  wire logic        I2C_SDA_IN,
	output logic             I2C_SDA_OUT,
	output logic             I2C_SDA_OE_N
);
	// ---------------- Pin synchronisers ----------------
	logic [1:0] din_sync_q;
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	wire        din_s = din_sync_q[1];
	wire        scl_s = scl_sync_q[1];
	wire        sda_s = sda_sync_q[1];

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			din_sync_q <= 2'h0;
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
		end else if (CLK_EN) begin
			din_sync_q <= {din_sync_q[0], DIN};
			scl_sync_q <= {scl_sync_q[0], I2C_SCL_IN};
			sda_sync_q <= {sda_sync_q[0], I2C_SDA_IN};
		end
	end

	// ---------------- Codec reference clock ----------------
	logic [15:0] ref_cnt_q;
	logic        ref_clk_q;
	wire         ref_wrap = (ref_cnt_q == 16'(REF_HALF - 1));

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ref_cnt_q <= 16'h0000;
			ref_clk_q <= 1'b0;
		end else if (CLK_EN) begin
			ref_cnt_q <= ref_wrap ? 16'h0000 : ref_cnt_q + 16'h0001;
			ref_clk_q <= ref_clk_q ^ ref_wrap;
		end
	end
	assign CODEC_REFERENCE_CLOCK_OUT = ref_clk_q;

	// ---------------- Audio link ----------------
	logic        run_q;
	logic        mode_q;
	logic        rate_q;
	logic [24:0] acc_q;
	logic        bclk_q;
	logic [4:0]  bit_q;
	logic        fs_q;
	logic        seen_fall_q;
	logic [15:0] tx_sh_q;
	logic [15:0] rx_sh_q;
	logic        rx_valid_q;
	logic [15:0] rx_data_q;
	logic        rx_slot_q;
	logic        underrun_q;

	// Rate and framing are caught at start so a live change cannot tear a frame
	wire         start    = AUDIO_EN && !run_q;
	wire [24:0]  inc      = mode_q ? (rate_q ? vsap_pkg::INC_I2S_HI : vsap_pkg::INC_I2S_LO)
	                               : (rate_q ? vsap_pkg::INC_PCM_HI : vsap_pkg::INC_PCM_LO);
	wire [24:0]  acc_sum  = acc_q + inc;
	wire         tick     = run_q && (acc_sum >= vsap_pkg::CLK_HZ);
	wire         fall     = tick && bclk_q;
	wire         rise     = tick && !bclk_q;
	wire [4:0]   fr_last  = mode_q ? vsap_pkg::I2S_LAST : vsap_pkg::PCM_LAST;
	wire [4:0]   bit_nx   = (bit_q == fr_last) ? vsap_pkg::BIT_FIRST : bit_q + 5'h01;
	wire         slot_new = (bit_nx[3:0] == vsap_pkg::WORD_FIRST);
	wire         ws_nx    = (bit_nx >= vsap_pkg::I2S_WS_RISE) && (bit_nx != vsap_pkg::I2S_LAST);
	wire         pcm_fs   = (bit_nx == vsap_pkg::PCM_LAST);
	wire         fs_nx    = mode_q ? ws_nx : pcm_fs;
	wire         word_end = (bit_q[3:0] == vsap_pkg::WORD_LAST);
	wire [15:0]  rx_word  = {rx_sh_q[14:0], din_s};

	wire         fifo_valid;
	wire [15:0]  fifo_data;
	// The serialiser is the only drain; it stalls the queue between slots
	wire         fifo_pop = fall && slot_new;

	vsap_fifo #(
		.WIDTH (vsap_pkg::WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (CLK_SYS),
		.rst       (SYS_RST || !run_q),
		.ce        (CLK_EN),
		.in_valid  (TX_VALID),
		.in_ready  (TX_READY),
		.in_data   (TX_DATA),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			run_q  <= 1'b0;
			mode_q <= 1'b0;
			rate_q <= 1'b0;
		end else if (CLK_EN) begin
			run_q <= AUDIO_EN;
			if (start) begin
				mode_q <= MODE_I2S;
				rate_q <= RATE_48K;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST || (CLK_EN && !run_q)) begin
			acc_q  <= 25'h0000000;
			bclk_q <= 1'b0;
		end else if (CLK_EN) begin
			acc_q  <= tick ? acc_sum - vsap_pkg::CLK_HZ : acc_sum;
			bclk_q <= bclk_q ^ tick;
		end
	end

	// Frame sync loaded at start reflects the last bit so the first falling edge opens a frame
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			bit_q       <= vsap_pkg::PCM_LAST;
			fs_q        <= 1'b0;
			tx_sh_q     <= 16'h0000;
			seen_fall_q <= 1'b0;
			underrun_q  <= 1'b0;
		end else if (CLK_EN) begin
			underrun_q <= fall && slot_new && !fifo_valid;
			if (start) begin
				bit_q       <= MODE_I2S ? vsap_pkg::I2S_LAST : vsap_pkg::PCM_LAST;
				fs_q        <= !MODE_I2S;
				tx_sh_q     <= 16'h0000;
				seen_fall_q <= 1'b0;
			end else if (!run_q) begin
				fs_q <= 1'b0;
			end else if (fall) begin
				bit_q       <= bit_nx;
				fs_q        <= fs_nx;
				seen_fall_q <= 1'b1;
				if (slot_new) begin
					// Empty queue sends silence rather than stale data
					tx_sh_q <= fifo_valid ? fifo_data : 16'h0000;
				end else begin
					tx_sh_q <= {tx_sh_q[14:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rx_sh_q    <= 16'h0000;
			rx_valid_q <= 1'b0;
			rx_data_q  <= 16'h0000;
			rx_slot_q  <= 1'b0;
		end else if (CLK_EN) begin
			rx_valid_q <= rise && seen_fall_q && word_end;
			if (rise) begin
				rx_sh_q <= rx_word;
				if (seen_fall_q && word_end) begin
					rx_data_q <= rx_word;
					rx_slot_q <= mode_q && bit_q[4];
				end
			end
		end
	end

	assign BCLK_OUT    = bclk_q;
	assign FSYNC_OUT   = fs_q;
	assign DOUT        = tx_sh_q[15];
	assign RX_VALID    = rx_valid_q;
	assign RX_DATA     = rx_data_q;
	assign RX_SLOT     = rx_slot_q;
	assign TX_UNDERRUN = underrun_q;

	// ---------------- Codec control bus master ----------------
	vsap_pkg::vsap_i2c_t st_q;
	vsap_pkg::vsap_i2c_t st_d;
	logic [11:0] q_cnt_q;
	logic [1:0]  byte_q;
	logic [3:0]  bitn_q;
	logic [23:0] msg_q;
	logic        scl_low_q;
	logic        sda_low_q;
	logic        nack_q;
	logic        done_q;
	logic        lost_q;

	wire q_done   = (q_cnt_q == vsap_pkg::I2C_Q_LAST);
	wire bus_free = scl_s && sda_s;
	wire ack_bit  = (bitn_q == vsap_pkg::I2C_ACK_BIT);
	wire my_bit   = ack_bit ? 1'b1 : msg_q[23];
	// Another master pulling data low while we release it means we lost the bus
	wire arb_lost = (st_q == vsap_pkg::I2C_HIGH) && scl_s && !ack_bit && my_bit && !sda_s;
	wire last_bit = ack_bit && (byte_q == vsap_pkg::I2C_BYTE_LAST);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			vsap_pkg::I2C_IDLE:  if (CFG_VALID) st_d = vsap_pkg::I2C_FREE;
			vsap_pkg::I2C_FREE:  if (bus_free && q_done) st_d = vsap_pkg::I2C_START;
			vsap_pkg::I2C_START: if (q_done) st_d = vsap_pkg::I2C_LOW;
			vsap_pkg::I2C_LOW:   if (q_done) st_d = vsap_pkg::I2C_HIGH;
			vsap_pkg::I2C_HIGH: begin
				if (arb_lost) begin
					st_d = vsap_pkg::I2C_DONE;
				end else if (scl_s && q_done) begin
					if (ack_bit && (sda_s || last_bit)) st_d = vsap_pkg::I2C_STOPA;
					else st_d = vsap_pkg::I2C_LOW;
				end
			end
			vsap_pkg::I2C_STOPA: if (q_done) st_d = vsap_pkg::I2C_STOPB;
			vsap_pkg::I2C_STOPB: if (scl_s && q_done) st_d = vsap_pkg::I2C_STOPC;
			vsap_pkg::I2C_STOPC: if (q_done) st_d = vsap_pkg::I2C_DONE;
			vsap_pkg::I2C_DONE:  st_d = vsap_pkg::I2C_IDLE;
			default:             st_d = vsap_pkg::I2C_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			st_q      <= vsap_pkg::I2C_IDLE;
			q_cnt_q   <= 12'h000;
			byte_q    <= 2'h0;
			bitn_q    <= 4'h0;
			msg_q     <= 24'h000000;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			nack_q    <= 1'b0;
			lost_q    <= 1'b0;
			done_q    <= 1'b0;
		end else if (CLK_EN) begin
			st_q   <= st_d;
			done_q <= (st_q == vsap_pkg::I2C_DONE);
			// Clock stretching: the count holds while a target keeps the clock low
			if (st_d != st_q || (st_q == vsap_pkg::I2C_FREE && !bus_free)) begin
				q_cnt_q <= 12'h000;
			end else if (!(st_q inside {vsap_pkg::I2C_HIGH, vsap_pkg::I2C_STOPB}) || scl_s) begin
				q_cnt_q <= q_done ? q_cnt_q : q_cnt_q + 12'h001;
			end
			unique case (st_q)
				vsap_pkg::I2C_IDLE: begin
					if (CFG_VALID) begin
						msg_q  <= {CFG_DEV_ADDR, 1'b0, CFG_REG_ADDR, CFG_WR_DATA};
						nack_q <= 1'b0;
						lost_q <= 1'b0;
						byte_q <= 2'h0;
						bitn_q <= 4'h0;
					end
				end
				vsap_pkg::I2C_START: sda_low_q <= 1'b1;
				vsap_pkg::I2C_LOW: begin
					scl_low_q <= 1'b1;
					// Data moves only once the clock is low, so no target sees a false start
					if (scl_low_q) begin
						sda_low_q <= !my_bit;
					end
				end
				vsap_pkg::I2C_HIGH: begin
					scl_low_q <= 1'b0;
					if (arb_lost) begin
						lost_q    <= 1'b1;
						sda_low_q <= 1'b0;
					end else if (scl_s && q_done) begin
						if (ack_bit) begin
							nack_q <= sda_s;
							bitn_q <= 4'h0;
							byte_q <= byte_q + 2'h1;
						end else begin
							bitn_q <= bitn_q + 4'h1;
							msg_q  <= {msg_q[22:0], 1'b0};
						end
						scl_low_q <= 1'b1;
					end
				end
				vsap_pkg::I2C_STOPA: sda_low_q <= 1'b1;
				vsap_pkg::I2C_STOPB: scl_low_q <= 1'b0;
				vsap_pkg::I2C_STOPC: sda_low_q <= 1'b0;
				default: begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
				end
			endcase
		end
	end

	// Open-drain only: the bus is pulled low or released, never driven high
	assign I2C_SCL_OUT  = 1'b0;
	assign I2C_SDA_OUT  = 1'b0;
	assign I2C_SCL_OE_N = !scl_low_q;
	assign I2C_SDA_OE_N = !sda_low_q;
	assign CFG_READY    = (st_q == vsap_pkg::I2C_IDLE);
	assign CFG_DONE     = done_q;
	assign CFG_NACK     = nack_q;
	assign CFG_ARB_LOST = lost_q;
endmodule // vsap_port
